// ==== hw/edt_edge_det.sv ====
// module: synchroniser, hold filter and edge selector for one request pin
`timescale 1ns/1ps
`default_nettype none
module edt_edge_det
#(
	parameter int FILT = edt_pkg::FILT_CYCLES
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	edt_edge_if.det   eif
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic       stable_ff;
	logic [7:0] cnt_ff;
	logic       nxt_stable;

	// two-flop synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
		end
	end

	// level must hold for the filter time before it counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= 8'h00;
		else if (sync2_ff == stable_ff)
			cnt_ff <= 8'h00;
		else if (cnt_ff != 8'(FILT - 1))
			cnt_ff <= cnt_ff + 8'h01;
	end

	assign nxt_stable = (sync2_ff != stable_ff && cnt_ff == 8'(FILT - 1)) ? sync2_ff : stable_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stable_ff <= 1'b0;
		else
			stable_ff <= nxt_stable;
	end

	// one-cycle pulse for a selected edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eif.edge_pulse <= 1'b0;
		else
			eif.edge_pulse <= (nxt_stable & ~stable_ff & eif.sel_rise)
				| (~nxt_stable & stable_ff & eif.sel_fall);
	end
endmodule // edt_edge_det
`default_nettype wire

// ==== hw/edt_edge_if.sv ====
// interface: one pin's edge selection and detected edge pulse
`timescale 1ns/1ps
`default_nettype none
interface edt_edge_if;
	logic sel_rise;
	logic sel_fall;
	logic edge_pulse;
	modport ctrl (output sel_rise, output sel_fall, input edge_pulse);
	modport det (input sel_rise, input sel_fall, output edge_pulse);
endinterface // edt_edge_if
`default_nettype wire

// ==== hw/edt_pkg.sv ====
// package: register map, reset values and constants for the edge detect and trap entry block
package edt_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] ADDR_RISE0    = 12'h000;
	localparam logic [11:0] ADDR_FALL0    = 12'h004;
	localparam logic [11:0] ADDR_RISEH    = 12'h008;
	localparam logic [11:0] ADDR_FALLH    = 12'h00C;
	localparam logic [11:0] ADDR_STATUS   = 12'h010;
	localparam logic [11:0] ADDR_EXC_PC   = 12'h014;
	localparam logic [11:0] ADDR_EXC_STAT = 12'h018;
	localparam logic [11:0] ADDR_CAUSE    = 12'h01C;
	localparam logic [11:0] ADDR_DBG_PC   = 12'h020;
	localparam logic [11:0] ADDR_DBG_STAT = 12'h024;
	localparam logic [11:0] ADDR_PIN_LVL  = 12'h028;
	// reset values
	localparam logic [7:0]  SEL_RESET     = 8'h00;
	localparam logic [31:0] STATUS_RESET  = 32'h0000_0020;
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
	// implemented bits of the selection registers
	localparam logic [7:0]  SEL0_MASK     = 8'h7C;
	localparam logic [7:0]  SELH_MASK     = 8'hE0;
	// bit positions
	localparam int          SEL0_NMI_BIT  = 2;
	localparam int          SEL0_PIN0_BIT = 3;
	localparam int          SELH_PIN4_BIT = 5;
	localparam int          STAT_BLK_BIT  = 5;
	localparam int          STAT_EXC_BIT  = 6;
	localparam int          STAT_NMI_BIT  = 7;
	localparam logic [31:0] STATUS_MASK   = 32'h0000_00FF;
	// handler vectors
	localparam logic [31:0] VEC_TRAP_LO   = 32'h0000_0040;
	localparam logic [31:0] VEC_TRAP_HI   = 32'h0000_0050;
	localparam logic [31:0] VEC_DEBUG     = 32'h0000_0060;
	localparam logic [4:0]  TRAP_HI_FIRST = 5'h10;
	// illegal opcode pattern
	localparam logic [5:0]  ILL_OPC       = 6'h3F;
	localparam logic [3:0]  ILL_SUB_MIN   = 4'h7;
	// noise filter hold time
	localparam int          FILT_NS       = 300;
	localparam int          CLK_NS        = 100;
	localparam int          FILT_CYCLES   = (FILT_NS + CLK_NS - 1) / CLK_NS;
	// entry and return kinds
	typedef enum logic [5:0]
	{
		EDT_OP_NONE    = 6'b00_0001,
		EDT_OP_TRAP    = 6'b00_0010,
		EDT_OP_ILL     = 6'b00_0100,
		EDT_OP_DBG     = 6'b00_1000,
		EDT_OP_EXC_RET = 6'b01_0000,
		EDT_OP_DBG_RET = 6'b10_0000
	} edt_op_t;
endpackage

// ==== hw/edt_top.sv ====
// module: external edge detection registers and exception entry and return sequencing
// Behaviour
// - each pin has rise and fall bits: none, rise, fall, or both edges
// - first pair: bit 2 is the nmi pin, bits 3..6 request pins 0..3
// - high pair: bits 5..7 request pins 4..6, bits 0..4 read zero
// - selection registers are 8 bits, read and write, zero after reset
// - after reset the nmi pin detects no edge and raises nothing
// - an edge counts only after the new level held the filter time; here nmi_wake follows an nmi level change without the filter
// - nmi edge detection must work with the clock stopped to wake standby; here nmi_wake comes from pclk flops and needs the clock
// - the software trap always raises an exception regardless of interrupt block
// - trap saves pc and status, writes cause low half, sets flags, jumps
// - trap vectors 10h..1fh go to 50h, lower vectors go to 40h
// - return from irq with exception flag reloads pc and status from exception save
// - exception flag is status bit 6; status resets to 00000020
// - illegal when bits 10..5 all ones, bits 26..23 at least 7, bit 16 zero
// - illegal trap saves to debug registers, sets three entry flags, jumps to 60h
// - debug break always accepted, same as the illegal trap
// - debug return reloads pc and status from the debug save registers
// - mask sets the block flag, unmask clears it; nmi and exceptions still taken
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module edt_top
#(
	parameter int NPINS = 7
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// pins
	input  wire logic             nmi_pin,
	input  wire logic [NPINS-1:0] ext_request_pins,
	output logic                  nmi_req,
	output logic      [NPINS-1:0] ext_req,
	output logic                  nmi_wake,
	// pipeline side
	input  wire logic             instr_valid,
	input  wire logic [31:0]      instr_word,
	input  wire logic [31:0]      instr_ret_pc,
	input  wire logic             trap_instr,
	input  wire logic [4:0]       trap_vector,
	input  wire logic [15:0]      trap_cause,
	input  wire logic             debug_break_instr,
	input  wire logic             return_from_irq_instr,
	input  wire logic             debug_return_instr,
	input  wire logic             mask_irq_instr,
	input  wire logic             unmask_irq_instr,
	output logic                  pc_load,
	output logic      [31:0]      pc_target,
	output logic                  illegal_opcode_trap,
	output logic      [31:0]      program_status_word_out
);
	logic [7:0]  ext_rise_select_0_ff;
	logic [7:0]  ext_fall_select_0_ff;
	logic [7:0]  ext_rise_select_high_ff;
	logic [7:0]  ext_fall_select_high_ff;
	logic [31:0] program_status_word_ff;
	logic [31:0] exc_saved_pc_ff;
	logic [31:0] exc_saved_status_ff;
	logic [31:0] exc_cause_reg_ff;
	logic [31:0] debug_saved_pc_ff;
	logic [31:0] debug_saved_status_ff;
	logic [31:0] prdata_ff;
	logic        pc_load_ff;
	logic [31:0] pc_target_ff;
	logic        nmi_lvl1_ff;
	logic        nmi_lvl2_ff;
	logic        nmi_wake_ff;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [31:0] rdmux;
	logic [31:0] status_entry;
	logic        is_ill;
	logic [NPINS-1:0] pins_meta_ff;
	logic [NPINS-1:0] pins_lvl_ff;
	edt_pkg::edt_op_t op;
	logic [NPINS:0] pin_vec;
	logic [NPINS:0] pulse_vec;

	// byte-lane merge of an 8-bit register
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s,
		input logic [7:0] m);
		merge8 = (s[0] ? d[7:0] : old) & m;
	endfunction

	// illegal opcode decode
	function automatic logic illegal_op(input logic [31:0] w);
		illegal_op = (w[10:5] == edt_pkg::ILL_OPC) && (w[26:23] >= edt_pkg::ILL_SUB_MIN) && !w[16];
	endfunction

	// apb strobes, zero wait states
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// address decode and read mux
	always_comb
	begin
		hit   = 1'b1;
		rdmux = edt_pkg::WORD_ZERO;
		case (paddr)
			edt_pkg::ADDR_RISE0:    rdmux = {24'h00_0000, ext_rise_select_0_ff};
			edt_pkg::ADDR_FALL0:    rdmux = {24'h00_0000, ext_fall_select_0_ff};
			edt_pkg::ADDR_RISEH:    rdmux = {24'h00_0000, ext_rise_select_high_ff};
			edt_pkg::ADDR_FALLH:    rdmux = {24'h00_0000, ext_fall_select_high_ff};
			edt_pkg::ADDR_STATUS:   rdmux = program_status_word_ff;
			edt_pkg::ADDR_EXC_PC:   rdmux = exc_saved_pc_ff;
			edt_pkg::ADDR_EXC_STAT: rdmux = exc_saved_status_ff;
			edt_pkg::ADDR_CAUSE:    rdmux = exc_cause_reg_ff;
			edt_pkg::ADDR_DBG_PC:   rdmux = debug_saved_pc_ff;
			edt_pkg::ADDR_DBG_STAT: rdmux = debug_saved_status_ff;
			edt_pkg::ADDR_PIN_LVL:  rdmux = {24'h00_0000, pins_lvl_ff, nmi_wake_ff};
			default:                hit   = 1'b0;
		endcase
	end

	// read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= edt_pkg::WORD_ZERO;
		else if (rd)
			prdata_ff <= rdmux;
	end
	assign prdata = prdata_ff;

	// pin levels for software: two flops, so the read mux never sees a moving pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pins_meta_ff <= '0;
			pins_lvl_ff  <= '0;
		end
		else
		begin
			pins_meta_ff <= ext_request_pins;
			pins_lvl_ff  <= pins_meta_ff;
		end
	end

	// edge selection registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_rise_select_0_ff    <= edt_pkg::SEL_RESET;
			ext_fall_select_0_ff    <= edt_pkg::SEL_RESET;
			ext_rise_select_high_ff <= edt_pkg::SEL_RESET;
			ext_fall_select_high_ff <= edt_pkg::SEL_RESET;
		end
		else if (wr)
		begin
			case (paddr)
				edt_pkg::ADDR_RISE0: ext_rise_select_0_ff <= merge8(ext_rise_select_0_ff, pwdata, pstrb,
					edt_pkg::SEL0_MASK);
				edt_pkg::ADDR_FALL0: ext_fall_select_0_ff <= merge8(ext_fall_select_0_ff, pwdata, pstrb,
					edt_pkg::SEL0_MASK);
				edt_pkg::ADDR_RISEH: ext_rise_select_high_ff <= merge8(ext_rise_select_high_ff, pwdata, pstrb,
					edt_pkg::SELH_MASK);
				edt_pkg::ADDR_FALLH: ext_fall_select_high_ff <= merge8(ext_fall_select_high_ff, pwdata, pstrb,
					edt_pkg::SELH_MASK);
				default: ;
			endcase
		end
	end

	// one detector per pin: index 0 is nmi, 1..NPINS are request pins
	assign pin_vec = {ext_request_pins, nmi_pin};
	genvar g;
	generate
		for (g = 0; g <= NPINS; g++)
		begin : g_det
			edt_edge_if eif ();
			if (g < 5)
			begin : g_lo
				assign eif.sel_rise = ext_rise_select_0_ff[edt_pkg::SEL0_NMI_BIT + g];
				assign eif.sel_fall = ext_fall_select_0_ff[edt_pkg::SEL0_NMI_BIT + g];
			end
			else
			begin : g_hi
				assign eif.sel_rise = ext_rise_select_high_ff[edt_pkg::SELH_PIN4_BIT + g - 5];
				assign eif.sel_fall = ext_fall_select_high_ff[edt_pkg::SELH_PIN4_BIT + g - 5];
			end
			edt_edge_det u_det
			(
				.pclk    (pclk),
				.presetn (presetn),
				.pin     (pin_vec[g]),
				.eif     (eif)
			);
			assign pulse_vec[g] = eif.edge_pulse;
		end
	endgenerate
	assign nmi_req = pulse_vec[0];
	assign ext_req = pulse_vec[NPINS:1];

	// nmi level for standby wake: synchronised, no filter so it follows the pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nmi_lvl1_ff <= 1'b0;
			nmi_lvl2_ff <= 1'b0;
			nmi_wake_ff <= 1'b0;
		end
		else
		begin
			nmi_lvl1_ff <= nmi_pin;
			nmi_lvl2_ff <= nmi_lvl1_ff;
			nmi_wake_ff <= nmi_lvl2_ff;
		end
	end
	// wake request: selected nmi level change, taken as a level outside the filter
	assign nmi_wake = (ext_rise_select_0_ff[edt_pkg::SEL0_NMI_BIT] & nmi_lvl2_ff & ~nmi_wake_ff)
		| (ext_fall_select_0_ff[edt_pkg::SEL0_NMI_BIT] & ~nmi_lvl2_ff & nmi_wake_ff);

	// instruction boundary decode, debug entries first
	assign is_ill = instr_valid & illegal_op(instr_word);
	assign illegal_opcode_trap = is_ill;
	always_comb
	begin
		op = edt_pkg::EDT_OP_NONE;
		if (instr_valid)
		begin
			if (is_ill)
				op = edt_pkg::EDT_OP_ILL;
			else if (debug_break_instr)
				op = edt_pkg::EDT_OP_DBG;
			else if (trap_instr)
				op = edt_pkg::EDT_OP_TRAP;
			else if (debug_return_instr)
				op = edt_pkg::EDT_OP_DBG_RET;
			else if (return_from_irq_instr && program_status_word_ff[edt_pkg::STAT_EXC_BIT])
				op = edt_pkg::EDT_OP_EXC_RET;
		end
	end

	// status with entry flags set
	always_comb
	begin
		status_entry = program_status_word_ff;
		status_entry[edt_pkg::STAT_EXC_BIT] = 1'b1;
		status_entry[edt_pkg::STAT_BLK_BIT] = 1'b1;
		if (op == edt_pkg::EDT_OP_ILL || op == edt_pkg::EDT_OP_DBG)
			status_entry[edt_pkg::STAT_NMI_BIT] = 1'b1;
	end

	// status word, save registers and cause, all updated in one edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			program_status_word_ff <= edt_pkg::STATUS_RESET;
			exc_saved_pc_ff        <= edt_pkg::WORD_ZERO;
			exc_saved_status_ff    <= edt_pkg::WORD_ZERO;
			exc_cause_reg_ff       <= edt_pkg::WORD_ZERO;
			debug_saved_pc_ff      <= edt_pkg::WORD_ZERO;
			debug_saved_status_ff  <= edt_pkg::WORD_ZERO;
		end
		else
		begin
			case (op)
				edt_pkg::EDT_OP_TRAP:
				begin
					exc_saved_pc_ff         <= instr_ret_pc;
					exc_saved_status_ff     <= program_status_word_ff;
					exc_cause_reg_ff[15:0]  <= trap_cause;
					program_status_word_ff  <= status_entry;
				end
				edt_pkg::EDT_OP_ILL, edt_pkg::EDT_OP_DBG:
				begin
					debug_saved_pc_ff       <= instr_ret_pc;
					debug_saved_status_ff   <= program_status_word_ff;
					program_status_word_ff  <= status_entry;
				end
				edt_pkg::EDT_OP_EXC_RET:
					program_status_word_ff  <= exc_saved_status_ff & edt_pkg::STATUS_MASK;
				edt_pkg::EDT_OP_DBG_RET:
					program_status_word_ff  <= debug_saved_status_ff & edt_pkg::STATUS_MASK;
				default:
				begin
					if (mask_irq_instr && instr_valid)
						program_status_word_ff[edt_pkg::STAT_BLK_BIT] <= 1'b1;
					else if (unmask_irq_instr && instr_valid)
						program_status_word_ff[edt_pkg::STAT_BLK_BIT] <= 1'b0;
					else if (wr && paddr == edt_pkg::ADDR_STATUS && pstrb[0])
						program_status_word_ff <= pwdata & edt_pkg::STATUS_MASK;
					if (wr && paddr == edt_pkg::ADDR_EXC_PC)
						exc_saved_pc_ff <= pwdata;
					if (wr && paddr == edt_pkg::ADDR_EXC_STAT)
						exc_saved_status_ff <= pwdata;
					if (wr && paddr == edt_pkg::ADDR_DBG_PC)
						debug_saved_pc_ff <= pwdata;
					if (wr && paddr == edt_pkg::ADDR_DBG_STAT)
						debug_saved_status_ff <= pwdata;
				end
			endcase
		end
	end
	assign program_status_word_out = program_status_word_ff;

	// pc redirect toward the pipeline
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_load_ff   <= 1'b0;
			pc_target_ff <= edt_pkg::WORD_ZERO;
		end
		else
		begin
			pc_load_ff <= (op != edt_pkg::EDT_OP_NONE);
			case (op)
				edt_pkg::EDT_OP_TRAP:  pc_target_ff <= (trap_vector >= edt_pkg::TRAP_HI_FIRST) ?
					edt_pkg::VEC_TRAP_HI : edt_pkg::VEC_TRAP_LO;
				edt_pkg::EDT_OP_ILL:   pc_target_ff <= edt_pkg::VEC_DEBUG;
				edt_pkg::EDT_OP_DBG:   pc_target_ff <= edt_pkg::VEC_DEBUG;
				edt_pkg::EDT_OP_EXC_RET: pc_target_ff <= exc_saved_pc_ff;
				edt_pkg::EDT_OP_DBG_RET: pc_target_ff <= debug_saved_pc_ff;
				default:               pc_target_ff <= pc_target_ff;
			endcase
		end
	end
	assign pc_load   = pc_load_ff;
	assign pc_target = pc_target_ff;
endmodule // edt_top
`default_nettype wire

// ==== tb/edt_pipe_model.sv ====
// model: instruction pipeline presenting one instruction per boundary
`timescale 1ns/1ps
`default_nettype none
module edt_pipe_model
(
	input  wire logic   pclk,
	output logic        instr_valid,
	output logic [31:0] instr_word,
	output logic [31:0] instr_ret_pc,
	output logic        trap_instr,
	output logic [4:0]  trap_vector,
	output logic [15:0] trap_cause,
	output logic        debug_break_instr,
	output logic        return_from_irq_instr,
	output logic        debug_return_instr,
	output logic        mask_irq_instr,
	output logic        unmask_irq_instr
);
	// idle pipeline at time zero
	initial
	begin
		instr_valid = 1'b0;
		{unmask_irq_instr, mask_irq_instr, debug_return_instr} = 3'b000;
		{return_from_irq_instr, debug_break_instr, trap_instr} = 3'b000;
		{instr_word, instr_ret_pc, trap_vector, trap_cause} = '0;
	end
	// one instruction held for exactly one boundary, data scrambled afterwards
	task issue(input logic [5:0] k, input logic [31:0] w, input logic [31:0] pc, input logic [4:0] v,
		input logic [15:0] c);
		@(posedge pclk);
		instr_valid <= 1'b1;
		{unmask_irq_instr, mask_irq_instr, debug_return_instr, return_from_irq_instr,
			debug_break_instr, trap_instr} <= k;
		instr_word <= w;
		instr_ret_pc <= pc;
		trap_vector <= v;
		trap_cause <= c;
		@(posedge pclk);
		instr_valid <= 1'b0;
		{unmask_irq_instr, mask_irq_instr, debug_return_instr, return_from_irq_instr,
			debug_break_instr, trap_instr} <= 6'h00;
		instr_word <= ~w;
		instr_ret_pc <= ~pc;
		trap_vector <= ~v;
		trap_cause <= ~c;
	endtask
endmodule // edt_pipe_model
`default_nettype wire

// ==== tb/edt_top_props.sv ====
// checker: concurrent properties on the edge detect and trap entry ports
`timescale 1ns/1ps
`default_nettype none
module edt_top_props
#(
	parameter int NPINS = 7
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             nmi_req,
	input  wire logic [NPINS-1:0] ext_req,
	input  wire logic             instr_valid,
	input  wire logic [31:0]      instr_word,
	input  wire logic             trap_instr,
	input  wire logic [4:0]       trap_vector,
	input  wire logic             debug_break_instr,
	input  wire logic             return_from_irq_instr,
	input  wire logic             debug_return_instr,
	input  wire logic             mask_irq_instr,
	input  wire logic             unmask_irq_instr,
	input  wire logic             pc_load,
	input  wire logic [31:0]      pc_target,
	input  wire logic             illegal_opcode_trap,
	input  wire logic [31:0]      program_status_word_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// entry kinds as the pipeline presents them
	sequence s_dbg;
		instr_valid && (debug_break_instr || illegal_opcode_trap);
	endsequence
	sequence s_trap;
		instr_valid && trap_instr && !debug_break_instr && !illegal_opcode_trap;
	endsequence
	sequence s_mask;
		instr_valid && mask_irq_instr && !unmask_irq_instr && !trap_instr && !debug_break_instr
			&& !illegal_opcode_trap && !return_from_irq_instr && !debug_return_instr;
	endsequence
	// opcode pattern of an illegal instruction
	logic ill_dec;
	assign ill_dec = instr_word[10:5] == 6'h3F && instr_word[26:23] >= 4'h7 && !instr_word[16];
	chk_ill_decode: assert property (illegal_opcode_trap == (instr_valid && ill_dec))
		else $error("illegal decode mismatch");
	chk_trap_vector: assert property (s_trap |=> pc_load && pc_target ==
		(($past(trap_vector) >= 5'h10) ? 32'h0000_0050 : 32'h0000_0040))
		else $error("trap vector wrong");
	chk_trap_flags: assert property (s_trap |=> program_status_word_out[6:5] == 2'b11)
		else $error("trap flags not set");
	chk_debug_entry: assert property (s_dbg |=> pc_load && pc_target == 32'h0000_0060
		&& program_status_word_out[7:5] == 3'b111)
		else $error("debug entry wrong");
	chk_mask_sets: assert property (s_mask |=> program_status_word_out[5])
		else $error("mask did not set block flag");
	chk_nmi_pulse: assert property (nmi_req |=> !nmi_req)
		else $error("nmi request longer than one cycle");
	chk_ext_pulse: assert property ((ext_req & $past(ext_req)) == '0)
		else $error("pin request longer than one cycle");
	chk_reset_psw: assert property ($rose(presetn) |-> program_status_word_out == 32'h0000_0020)
		else $error("status word reset value wrong");
	chk_reset_quiet: assert property ($rose(presetn) |-> !nmi_req [*3])
		else $error("nmi request after reset");
endmodule // edt_top_props
bind edt_top edt_top_props #(.NPINS(NPINS)) u_props
(
	.pclk(pclk), .presetn(presetn), .nmi_req(nmi_req), .ext_req(ext_req),
	.instr_valid(instr_valid), .instr_word(instr_word), .trap_instr(trap_instr),
	.trap_vector(trap_vector), .debug_break_instr(debug_break_instr),
	.return_from_irq_instr(return_from_irq_instr), .debug_return_instr(debug_return_instr),
	.mask_irq_instr(mask_irq_instr), .unmask_irq_instr(unmask_irq_instr), .pc_load(pc_load),
	.pc_target(pc_target), .illegal_opcode_trap(illegal_opcode_trap),
	.program_status_word_out(program_status_word_out)
);
`default_nettype wire

// ==== tb/test_edt_top.sv ====
// testbench: register, pin edge and trap entry scenarios for the block
`timescale 1ns/1ps
`default_nettype none
module test_edt_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, pc_target, stat, iw, ipc, q;
	logic [3:0]  pstrb = 4'hF;
	logic        nmi_pin = 1'b0, pready, pslverr, nmi_req, pc_load, err, wake;
	logic [6:0]  pins = '0, ext_req;
	logic        iv, tr, db, rt, dr, mk, um;
	logic [4:0]  tv;
	logic [15:0] tc;
	int          n_mismatch = 0, check_count = 0, n_nmi = 0, n_e0 = 0, n_e4 = 0, n_wake = 0, b, bw;
	logic [11:0] sa [4] = '{edt_pkg::ADDR_RISE0, edt_pkg::ADDR_FALL0, edt_pkg::ADDR_RISEH, edt_pkg::ADDR_FALLH};
	logic [7:0]  sm [4] = '{edt_pkg::SEL0_MASK, edt_pkg::SEL0_MASK, edt_pkg::SELH_MASK, edt_pkg::SELH_MASK};
	edt_top u_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nmi_pin(nmi_pin), .ext_request_pins(pins), .nmi_req(nmi_req), .ext_req(ext_req), .nmi_wake(wake),
		.instr_valid(iv), .instr_word(iw), .instr_ret_pc(ipc), .trap_instr(tr), .trap_vector(tv),
		.trap_cause(tc), .debug_break_instr(db), .return_from_irq_instr(rt), .debug_return_instr(dr),
		.mask_irq_instr(mk), .unmask_irq_instr(um), .pc_load(pc_load), .pc_target(pc_target),
		.illegal_opcode_trap(), .program_status_word_out(stat)
	);
	edt_pipe_model u_pipe
	(
		.pclk(pclk), .instr_valid(iv), .instr_word(iw), .instr_ret_pc(ipc), .trap_instr(tr),
		.trap_vector(tv), .trap_cause(tc), .debug_break_instr(db), .return_from_irq_instr(rt),
		.debug_return_instr(dr), .mask_irq_instr(mk), .unmask_irq_instr(um)
	);
	// clock and request pulse counters
	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		n_nmi += (nmi_req === 1'b1);
		n_e0 += (ext_req[0] === 1'b1);
		n_e4 += (ext_req[4] === 1'b1);
		n_wake += (wake === 1'b1);
	end
	task close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_mismatch++;
			close_out();
		end
		else
		begin
			q = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one boundary instruction and the redirect it must or must not cause
	task ent(input logic [5:0] k, input logic [31:0] w, input logic [31:0] pc, input logic [4:0] v,
		input logic ld, input logic [31:0] t);
		u_pipe.issue(k, w, pc, v, 16'h1234);
		#1;
		chk("pc load", {31'h0, ld}, {31'h0, pc_load});
		if (ld)
			chk("pc target", t, pc_target);
	endtask
	// main sequence
	initial
	begin
		tick(16);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			rd("select reset", sa[k], 32'h0000_0000);
			apb(1'b1, sa[k], 32'h0000_00FF);
			rd("select bits", sa[k], {24'h0, sm[k]});
			apb(1'b1, sa[k], 32'h0000_0000);
		end
		rd("status reset", edt_pkg::ADDR_STATUS, 32'h0000_0020);
		pstrb <= 4'h0;
		apb(1'b1, edt_pkg::ADDR_RISE0, 32'h0000_00FF);
		pstrb <= 4'hF;
		rd("no lane write", edt_pkg::ADDR_RISE0, 32'h0000_0000);
		rd("unmapped read", 12'h040, 32'h0000_0000);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test registers done");
		b = n_nmi;
		bw = n_wake;
		nmi_pin <= 1'b1;
		tick(10);
		nmi_pin <= 1'b0;
		tick(12);
		chk("nmi unselected", b, n_nmi);
		apb(1'b1, edt_pkg::ADDR_RISE0, 32'h0000_0004);
		nmi_pin <= 1'b1;
		tick(1);
		nmi_pin <= 1'b0;
		tick(12);
		chk("nmi glitch", b, n_nmi);
		nmi_pin <= 1'b1;
		tick(12);
		nmi_pin <= 1'b0;
		tick(12);
		chk("nmi rise only", b + 1, n_nmi);
		chk("nmi wake", bw + 2, n_wake);
		apb(1'b1, edt_pkg::ADDR_RISE0, 32'h0000_0000);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, edt_pkg::ADDR_RISE0, m[0] ? 32'h0000_0008 : 32'h0000_0000);
			apb(1'b1, edt_pkg::ADDR_FALL0, m[1] ? 32'h0000_0008 : 32'h0000_0000);
			b = n_e0;
			pins[0] <= 1'b1;
			tick(12);
			pins[0] <= 1'b0;
			tick(12);
			chk("pin0 edges", b + m[0] + m[1], n_e0);
		end
		apb(1'b1, edt_pkg::ADDR_RISE0, 32'h0000_0000);
		apb(1'b1, edt_pkg::ADDR_FALL0, 32'h0000_0000);
		apb(1'b1, edt_pkg::ADDR_RISEH, 32'h0000_0020);
		b = n_e4;
		pins[4] <= 1'b1;
		tick(12);
		pins[4] <= 1'b0;
		tick(12);
		chk("pin4 edges", b + 1, n_e4);
		apb(1'b1, edt_pkg::ADDR_RISEH, 32'h0000_0000);
		$display("test pins done");
		ent(6'h20, 32'h0, 32'h0, 5'h0, 1'b0, 32'h0);
		rd("unmask", edt_pkg::ADDR_STATUS, 32'h0000_0000);
		ent(6'h10, 32'h0, 32'h0, 5'h0, 1'b0, 32'h0);
		rd("mask", edt_pkg::ADDR_STATUS, 32'h0000_0020);
		ent(6'h01, 32'h0, 32'h0000_0100, 5'h0F, 1'b1, edt_pkg::VEC_TRAP_LO);
		rd("exc pc", edt_pkg::ADDR_EXC_PC, 32'h0000_0100);
		rd("exc status", edt_pkg::ADDR_EXC_STAT, 32'h0000_0020);
		rd("cause", edt_pkg::ADDR_CAUSE, 32'h0000_1234);
		rd("trap status", edt_pkg::ADDR_STATUS, 32'h0000_0060);
		ent(6'h01, 32'h0, 32'h0000_0104, 5'h10, 1'b1, edt_pkg::VEC_TRAP_HI);
		rd("exc status 2", edt_pkg::ADDR_EXC_STAT, 32'h0000_0060);
		ent(6'h04, 32'h0, 32'h0, 5'h0, 1'b1, 32'h0000_0104);
		rd("return status", edt_pkg::ADDR_STATUS, 32'h0000_0060);
		apb(1'b1, edt_pkg::ADDR_STATUS, 32'h0000_0000);
		ent(6'h04, 32'h0, 32'h0, 5'h0, 1'b0, 32'h0);
		$display("test traps done");
		ent(6'h00, 32'h0300_07E0, 32'h0000_0200, 5'h0, 1'b0, 32'h0);
		ent(6'h00, 32'h0381_07E0, 32'h0000_0200, 5'h0, 1'b0, 32'h0);
		ent(6'h00, 32'h0380_07E0, 32'h0000_0204, 5'h0, 1'b1, edt_pkg::VEC_DEBUG);
		rd("dbg pc", edt_pkg::ADDR_DBG_PC, 32'h0000_0204);
		rd("dbg status", edt_pkg::ADDR_DBG_STAT, 32'h0000_0000);
		rd("ill status", edt_pkg::ADDR_STATUS, 32'h0000_00E0);
		ent(6'h08, 32'h0, 32'h0, 5'h0, 1'b1, 32'h0000_0204);
		rd("debug return status", edt_pkg::ADDR_STATUS, 32'h0000_0000);
		ent(6'h02, 32'h0, 32'h0000_0300, 5'h0, 1'b1, edt_pkg::VEC_DEBUG);
		rd("break pc", edt_pkg::ADDR_DBG_PC, 32'h0000_0300);
		rd("break status", edt_pkg::ADDR_STATUS, 32'h0000_00E0);
		$display("test debug done");
		close_out();
	end
endmodule // test_edt_top
`default_nettype wire
